// >>> rtl/ips_consts.svh
// Constants for the interrupt priority selection block
`ifndef IPS_CONSTS_SVH
`define IPS_CONSTS_SVH

// ------------------------------------------------------------
// Register placement and values
// ------------------------------------------------------------
`define IPS_SFR_ADDR     8'hB8
`define IPS_BIT_BASE     5'h17
`define IPS_RESET_PRIO   6'h00
`define IPS_UNUSED_READ  2'h3
`define IPS_IDLE_BYTE    8'h00

// ------------------------------------------------------------
// Field positions, lowest index wins a tie
// ------------------------------------------------------------
`define IPS_SRC_CNT      6
`define IPS_BIT_EXT0     0
`define IPS_BIT_TIMER0   1
`define IPS_BIT_EXT1     2
`define IPS_BIT_TIMER1   3
`define IPS_BIT_SERIAL   4
`define IPS_BIT_TIMER2   5
`define IPS_BIT_UNUSED_LO 6
`define IPS_NO_SOURCE    3'h0

`endif

// >>> rtl/ips_pkg.sv
// Types shared by the interrupt priority selection block
package ips_pkg;

  // Service nesting: one-hot, at most one low level under one high level
  typedef enum logic [3:0] {
    IPS_SVC_IDLE      = 4'h1,
    IPS_SVC_LOW       = 4'h2,
    IPS_SVC_HIGH      = 4'h4,
    IPS_SVC_HIGH_LOW  = 4'h8
  } ips_svc_t;

endpackage

// >>> rtl/ips_fixed_order_pick.sv
// Fixed-order picker: lowest set request index wins
`timescale 1ns/1ns
`include "ips_consts.svh"

module ips_fixed_order_pick (
  // Requests
  input  wire logic [5:0] req,
  // Result
  output logic            any,
  output logic [2:0]      idx
);

  always_comb begin
    any = 1'b0;
    idx = `IPS_NO_SOURCE;
    for (int i = `IPS_SRC_CNT - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = 3'(i);
      end
    end
  end

endmodule // ips_fixed_order_pick

// >>> rtl/ips_interrupt_priority_select.sv
// Interrupt priority selection register with two-level request arbitration
//
// How it works
// - Register sits at special function address 0xB8; each bit is bit-addressable.
// - Reset clears the register; all six sources start at low priority.
// - Bits 7 and 6 always read as one; writes to them are ignored.
// - Bit 5 set makes the second timer interrupt high priority.
// - Bit 4 set makes the serial port interrupt high priority.
// - Bit 3 set makes the timer one interrupt high priority.
// - Bit 1 set makes the timer zero interrupt high priority.
// - Bit 0 set makes external pin zero interrupt high priority.
`timescale 1ns/1ns
`include "ips_consts.svh"

module ips_interrupt_priority_select (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  // Byte access to the special function space
  input  wire logic [7:0] sfrAddr,
  input  wire logic       sfrWrEn,
  input  wire logic [7:0] sfrWrData,
  input  wire logic       sfrRdEn,
  output logic [7:0]      sfrRdData,
  // Bit access to the bit-addressable space
  input  wire logic [7:0] bitAddr,
  input  wire logic       bitWrEn,
  input  wire logic       bitWrVal,
  input  wire logic       bitRdEn,
  output logic            bitRdData,
  // Enabled, pending requests from the six sources
  input  wire logic [5:0] irqReq,
  // Core handshake
  input  wire logic       vectorTaken,
  input  wire logic       serviceDone,
  output logic            irqValid,
  output logic [2:0]      irqSource,
  output logic            irqHigh,
  output logic            inServiceLow,
  output logic            inServiceHigh,
  // Priority levels as seen by the arbitration
  output logic            timer_two_high_priority,
  output logic            serial_port_high_priority,
  output logic            timer_one_high_priority,
  output logic            ext_pin_one_high_priority,
  output logic            timer_zero_high_priority,
  output logic            ext_pin_zero_high_priority
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [5:0]       prio_ff;
  logic [5:0]       nxt_prio;
  logic [7:0]       sfrRdData_ff;
  logic             bitRdData_ff;
  logic             irqValid_ff;
  logic [2:0]       irqSource_ff;
  logic             irqHigh_ff;
  logic             inServiceLow_ff;
  logic             inServiceHigh_ff;
  ips_pkg::ips_svc_t svc_ff;
  ips_pkg::ips_svc_t nxt_svc;
  logic             byteHit;
  logic             bitWrHit;
  logic             bitRdHit;
  logic [2:0]       bitSel;
  logic [7:0]       readView;
  logic             highAny;
  logic [2:0]       highIdx;
  logic             lowAny;
  logic [2:0]       lowIdx;
  logic             highOk;
  logic             lowOk;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  function automatic logic bit_in_reg(input logic [7:0] addr);
    bit_in_reg = (addr[7:3] == `IPS_BIT_BASE);
  endfunction

  assign byteHit  = (sfrAddr == `IPS_SFR_ADDR);
  assign bitWrHit = bitWrEn && bit_in_reg(bitAddr);
  assign bitRdHit = bitRdEn && bit_in_reg(bitAddr);
  assign bitSel   = bitAddr[2:0];
  assign readView = {`IPS_UNUSED_READ, prio_ff};

  // ------------------------------------------------------------
  // Priority register
  // ------------------------------------------------------------
  // Bit write lands after a byte write of the same cycle, so it wins
  always_comb begin
    nxt_prio = prio_ff;
    if (sfrWrEn && byteHit) begin
      nxt_prio = sfrWrData[5:0];
    end
    if (bitWrHit && (bitSel < 3'(`IPS_BIT_UNUSED_LO))) begin
      nxt_prio[bitSel] = bitWrVal;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prio_ff <= `IPS_RESET_PRIO;
    end else begin
      prio_ff <= nxt_prio;
    end
  end

  // ------------------------------------------------------------
  // Read paths, one cycle after the strobe
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sfrRdData_ff <= `IPS_IDLE_BYTE;
    end else if (sfrRdEn && byteHit) begin
      sfrRdData_ff <= readView;
    end else begin
      sfrRdData_ff <= `IPS_IDLE_BYTE;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bitRdData_ff <= 1'b0;
    end else begin
      bitRdData_ff <= bitRdHit && readView[bitSel];
    end
  end

  // ------------------------------------------------------------
  // Request split by level
  // ------------------------------------------------------------
  ips_fixed_order_pick u_pick_high (
    .req (irqReq & prio_ff),
    .any (highAny),
    .idx (highIdx)
  );

  ips_fixed_order_pick u_pick_low (
    .req (irqReq & ~prio_ff),
    .any (lowAny),
    .idx (lowIdx)
  );

  // ------------------------------------------------------------
  // Service nesting
  // ------------------------------------------------------------
  // Core is expected never to take a vector and finish one together;
  // if it does, finishing is handled and the take is dropped
  always_comb begin
    nxt_svc = svc_ff;
    unique case (svc_ff)
      ips_pkg::IPS_SVC_IDLE: begin
        if (vectorTaken && irqValid_ff) begin
          nxt_svc = irqHigh_ff ? ips_pkg::IPS_SVC_HIGH : ips_pkg::IPS_SVC_LOW;
        end
      end
      ips_pkg::IPS_SVC_LOW: begin
        if (serviceDone) begin
          nxt_svc = ips_pkg::IPS_SVC_IDLE;
        end else if (vectorTaken && irqValid_ff && irqHigh_ff) begin
          nxt_svc = ips_pkg::IPS_SVC_HIGH_LOW;
        end
      end
      ips_pkg::IPS_SVC_HIGH: begin
        if (serviceDone) begin
          nxt_svc = ips_pkg::IPS_SVC_IDLE;
        end
      end
      ips_pkg::IPS_SVC_HIGH_LOW: begin
        if (serviceDone) begin
          nxt_svc = ips_pkg::IPS_SVC_LOW;
        end
      end
      default: begin
        nxt_svc = ips_pkg::IPS_SVC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      svc_ff <= ips_pkg::IPS_SVC_IDLE;
    end else begin
      svc_ff <= nxt_svc;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      inServiceLow_ff  <= 1'b0;
      inServiceHigh_ff <= 1'b0;
    end else begin
      inServiceLow_ff  <= (nxt_svc == ips_pkg::IPS_SVC_LOW) ||
                          (nxt_svc == ips_pkg::IPS_SVC_HIGH_LOW);
      inServiceHigh_ff <= (nxt_svc == ips_pkg::IPS_SVC_HIGH) ||
                          (nxt_svc == ips_pkg::IPS_SVC_HIGH_LOW);
    end
  end

  // ------------------------------------------------------------
  // Arbitration
  // ------------------------------------------------------------
  // Eligibility looks at the next nesting state so a just-taken
  // request is not offered twice
  assign highOk = highAny && (nxt_svc == ips_pkg::IPS_SVC_IDLE ||
                              nxt_svc == ips_pkg::IPS_SVC_LOW);
  assign lowOk  = lowAny && (nxt_svc == ips_pkg::IPS_SVC_IDLE);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irqValid_ff  <= 1'b0;
      irqSource_ff <= `IPS_NO_SOURCE;
      irqHigh_ff   <= 1'b0;
    end else if (highOk) begin
      irqValid_ff  <= 1'b1;
      irqSource_ff <= highIdx;
      irqHigh_ff   <= 1'b1;
    end else if (lowOk) begin
      irqValid_ff  <= 1'b1;
      irqSource_ff <= lowIdx;
      irqHigh_ff   <= 1'b0;
    end else begin
      irqValid_ff  <= 1'b0;
      irqSource_ff <= `IPS_NO_SOURCE;
      irqHigh_ff   <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign sfrRdData     = sfrRdData_ff;
  assign bitRdData     = bitRdData_ff;
  assign irqValid      = irqValid_ff;
  assign irqSource     = irqSource_ff;
  assign irqHigh       = irqHigh_ff;
  assign inServiceLow  = inServiceLow_ff;
  assign inServiceHigh = inServiceHigh_ff;

  assign timer_two_high_priority    = prio_ff[`IPS_BIT_TIMER2];
  assign serial_port_high_priority  = prio_ff[`IPS_BIT_SERIAL];
  assign timer_one_high_priority    = prio_ff[`IPS_BIT_TIMER1];
  assign ext_pin_one_high_priority  = prio_ff[`IPS_BIT_EXT1];
  assign timer_zero_high_priority   = prio_ff[`IPS_BIT_TIMER0];
  assign ext_pin_zero_high_priority = prio_ff[`IPS_BIT_EXT0];

endmodule // ips_interrupt_priority_select

// >>> testbench/ips_assertions.sv
// Concurrent checks on the priority selection block ports
`timescale 1ns/1ns
`include "ips_consts.svh"
module ips_assertions (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       arst_n,
  // Register access
  input wire logic [7:0] sfrAddr,
  input wire logic       sfrWrEn,
  input wire logic [7:0] sfrWrData,
  input wire logic       sfrRdEn,
  input wire logic [7:0] sfrRdData,
  input wire logic [7:0] bitAddr,
  input wire logic       bitWrEn,
  input wire logic       bitWrVal,
  // Arbitration
  input wire logic       vectorTaken,
  input wire logic       serviceDone,
  input wire logic       irqValid,
  input wire logic       irqHigh,
  input wire logic       inServiceLow,
  input wire logic       inServiceHigh,
  // Priority levels
  input wire logic       timer_two_high_priority,
  input wire logic       serial_port_high_priority,
  input wire logic       timer_one_high_priority,
  input wire logic       ext_pin_one_high_priority,
  input wire logic       timer_zero_high_priority,
  input wire logic       ext_pin_zero_high_priority
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic [5:0] prio;
  assign prio = {timer_two_high_priority, serial_port_high_priority, timer_one_high_priority,
                 ext_pin_one_high_priority, timer_zero_high_priority, ext_pin_zero_high_priority};
  sequence quietRd;
    sfrRdEn && sfrAddr == `IPS_SFR_ADDR && !sfrWrEn && !bitWrEn;
  endsequence
  sequence byteWr;
    sfrWrEn && sfrAddr == `IPS_SFR_ADDR && !bitWrEn;
  endsequence
  // Nesting steps: an offer is taken, then the matching level is in service
  sequence takeHigh;
    irqValid && irqHigh && vectorTaken && !serviceDone;
  endsequence
  sequence takeLow;
    irqValid && !irqHigh && vectorTaken && !serviceDone;
  endsequence
  rd_value_a: assert property (quietRd |=> sfrRdData == {2'h3, prio})
    else $error("read byte differs from levels");
  rd_idle_a: assert property (!(sfrRdEn && sfrAddr == `IPS_SFR_ADDR) |=> sfrRdData == 8'h00)
    else $error("read data without a hit");
  byte_wr_a: assert property (byteWr |=> prio == $past(sfrWrData[5:0]))
    else $error("byte write not applied");
  bit_wr_a: assert property (bitWrEn && bitAddr[7:3] == `IPS_BIT_BASE && bitAddr[2:0] < 3'h6
    |=> prio[$past(bitAddr[2:0])] == $past(bitWrVal)) else $error("bit write not applied");
  prio_hold_a: assert property (!sfrWrEn && !bitWrEn |=> $stable(prio))
    else $error("levels changed without write");
  reset_clear_a: assert property ($rose(arst_n) |-> prio == 6'h00)
    else $error("levels not cleared by reset");
  high_nest_a: assert property (inServiceHigh |-> !irqValid)
    else $error("offer while serving high");
  low_nest_a: assert property (inServiceLow && irqValid |-> irqHigh)
    else $error("low offer while serving low");
  take_high_a: assert property (takeHigh |=> inServiceHigh)
    else $error("high take not in service");
  take_low_a: assert property (takeLow |=> inServiceLow && !inServiceHigh)
    else $error("low take not in service");
endmodule // ips_assertions
bind ips_interrupt_priority_select ips_assertions ips_assertions_i (
  .core_clk(core_clk), .arst_n(arst_n), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
  .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData), .bitAddr(bitAddr),
  .bitWrEn(bitWrEn), .bitWrVal(bitWrVal), .vectorTaken(vectorTaken),
  .serviceDone(serviceDone), .irqValid(irqValid), .irqHigh(irqHigh),
  .inServiceLow(inServiceLow), .inServiceHigh(inServiceHigh),
  .timer_two_high_priority(timer_two_high_priority),
  .serial_port_high_priority(serial_port_high_priority),
  .timer_one_high_priority(timer_one_high_priority),
  .ext_pin_one_high_priority(ext_pin_one_high_priority),
  .timer_zero_high_priority(timer_zero_high_priority),
  .ext_pin_zero_high_priority(ext_pin_zero_high_priority));

// >>> testbench/ips_interrupt_priority_select_tb.sv
// Testbench for the priority selection block
`timescale 1ns/1ns
module ips_interrupt_priority_select_tb;
  logic       core_clk, arst_n, sfrWrEn, sfrRdEn, bitWrEn, bitWrVal, bitRdEn;
  logic       vectorTaken, serviceDone;
  logic [7:0] sfrAddr, sfrWrData, bitAddr;
  logic [5:0] irqReq;
  wire  [7:0] sfrRdData;
  wire        bitRdData, irqValid, irqHigh, inServiceLow, inServiceHigh;
  wire  [2:0] irqSource;
  wire  [5:0] prio;
  int         errTotal, comparisons, cycles;
  ips_interrupt_priority_select ips_interrupt_priority_select_i (
    .core_clk(core_clk), .arst_n(arst_n), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
    .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData), .bitAddr(bitAddr),
    .bitWrEn(bitWrEn), .bitWrVal(bitWrVal), .bitRdEn(bitRdEn), .bitRdData(bitRdData),
    .irqReq(irqReq), .vectorTaken(vectorTaken), .serviceDone(serviceDone),
    .irqValid(irqValid), .irqSource(irqSource), .irqHigh(irqHigh),
    .inServiceLow(inServiceLow), .inServiceHigh(inServiceHigh),
    .timer_two_high_priority(prio[5]), .serial_port_high_priority(prio[4]),
    .timer_one_high_priority(prio[3]), .ext_pin_one_high_priority(prio[2]),
    .timer_zero_high_priority(prio[1]), .ext_pin_zero_high_priority(prio[0]));
  // ----------------------------------------
  // Access tasks, each two cycles long
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errTotal++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfrAddr = a; sfrWrData = d; sfrWrEn = 1'b1;
    @(negedge core_clk); sfrWrEn = 1'b0; @(negedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfrAddr = a; sfrRdEn = 1'b1;
    @(negedge core_clk); sfrRdEn = 1'b0; chk(sfrRdData, e); @(negedge core_clk);
  endtask
  task automatic bwr(input logic [7:0] a, input logic v);
    bitAddr = a; bitWrVal = v; bitWrEn = 1'b1;
    @(negedge core_clk); bitWrEn = 1'b0; @(negedge core_clk);
  endtask
  task automatic brd(input logic [7:0] a, input logic e);
    bitAddr = a; bitRdEn = 1'b1;
    @(negedge core_clk); bitRdEn = 1'b0; chk({7'h00, bitRdData}, {7'h00, e});
    @(negedge core_clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Generous ceiling, the tests need about 100 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errTotal++;
      report_and_stop;
    end
  end
  initial begin
    {arst_n, sfrWrEn, sfrRdEn, bitWrEn, bitWrVal, bitRdEn, vectorTaken, serviceDone} = 8'h00;
    {sfrAddr, sfrWrData, bitAddr} = 24'h000000;
    irqReq = 6'h00;
    repeat (16) @(negedge core_clk);
    arst_n = 1'b1;
    chk({2'h0, prio}, 8'h00);
    rd(8'hB8, 8'hC0);
    wr(8'hB8, 8'hC0); rd(8'hB8, 8'hC0);
    for (int i = 0; i < 6; i++) begin
      wr(8'hB8, 8'h01 << i); chk({2'h0, prio}, 8'h01 << i);
      rd(8'hB8, 8'hC0 | (8'h01 << i));
    end
    wr(8'hB0, 8'h3F); rd(8'hA8, 8'h00); rd(8'hB8, 8'hE0);
    $display("test byte access done");
    wr(8'hB8, 8'h00);
    for (int i = 0; i < 8; i++) bwr(8'hB8 + 8'(i), 1'b1);
    rd(8'hB8, 8'hFF);
    bwr(8'hBE, 1'b0); brd(8'hBE, 1'b1); brd(8'hBF, 1'b1);
    bwr(8'hB9, 1'b0); brd(8'hB9, 1'b0); brd(8'hB8, 1'b1); rd(8'hB8, 8'hFD);
    $display("test bit access done");
    wr(8'hB8, 8'h00);
    irqReq = 6'h02; @(negedge core_clk);
    chk({irqValid, irqHigh, irqSource}, 8'h11);
    vectorTaken = 1'b1; @(negedge core_clk); vectorTaken = 1'b0;
    chk({inServiceHigh, inServiceLow, irqValid}, 8'h02);
    wr(8'hB8, 8'h10); irqReq = 6'h12; @(negedge core_clk);
    chk({irqValid, irqHigh, irqSource}, 8'h1C);
    vectorTaken = 1'b1; @(negedge core_clk); vectorTaken = 1'b0; irqReq = 6'h13;
    @(negedge core_clk); chk({inServiceHigh, irqValid}, 8'h02);
    serviceDone = 1'b1; irqReq = 6'h03; @(negedge core_clk); serviceDone = 1'b0;
    chk({inServiceHigh, inServiceLow, irqValid}, 8'h02);
    @(negedge core_clk); serviceDone = 1'b1; @(negedge core_clk); serviceDone = 1'b0;
    chk({irqValid, irqHigh, irqSource}, 8'h10);
    $display("test arbitration done");
    report_and_stop;
  end
endmodule // ips_interrupt_priority_select_tb
